/* design/rav_voter.sv */
// redundant analog input voter: capture, per-channel vote, table readout

// Behaviour
// - vote runs once per scan, after capture, before the application starts.
// - inputs of non-redundant blocks are stored apart and never voted.
// - voted results sit at the start of the input table, ahead of copies.
// - voted word for channel n is the group's voted word n.
// - a copy with a discrepancy or bus fault is excluded for that channel.
// - group degrades three to two, then to one copy or the fallback.
// - three valid copies give their median; policy and fallback unused.
// - two-copy policy is higher, lower or average.
// - two-block groups and three-block groups missing one use the policy.
// - lowest policy puts channel minimum in as third, takes the median.
// - highest policy puts channel maximum in as third, takes the median.
// - average policy outputs the mean of the two remaining copies.
// - one remaining copy means no vote: copy or fallback by mode.
// - full mode with one valid copy outputs that copy unchanged.
// - truncated mode with one valid copy left of two or three outputs the fallback.
// - fallback is last held value, configured maximum or configured minimum.
// - single-copy group whose copy fails outputs the fallback.
// - full mode group outputs fallback when its last copy fails.
// - truncated mode two-block group outputs fallback when either copy fails.
// - single-copy group outputs its valid copy as captured at the scan, unvoted.
module rav_voter
(
    input wire logic clk_sys_in,
    input wire logic nrst_in,
    input wire logic scan_done_in,
    input wire logic [rav_pkg::CH_N*rav_pkg::DW-1:0] copy_a_in,
    input wire logic [rav_pkg::CH_N*rav_pkg::DW-1:0] copy_b_in,
    input wire logic [rav_pkg::CH_N*rav_pkg::DW-1:0] copy_c_in,
    input wire logic [rav_pkg::CH_N*3-1:0] disc_fault_in,
    input wire logic [2:0] bus_fault_in,
    input wire logic [rav_pkg::NV_N*rav_pkg::DW-1:0] nonvoted_in,
    input wire logic [rav_pkg::AW-1:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [31:0] rdata_out,
    output logic busy_out,
    output logic vote_done_out,
    output logic [rav_pkg::CH_N*rav_pkg::DW-1:0] voted_out
);
    // ==========================================================
    // state
    typedef logic [rav_pkg::CH_N-1:0][rav_pkg::DW-1:0] rav_chan_t;

    typedef struct packed
    {
        rav_pkg::rav_state_t st;
        logic [rav_pkg::CW-1:0] idx;
        logic [rav_pkg::CTRL_W-1:0] ctrl;
        rav_chan_t min_val;
        rav_chan_t max_val;
        rav_chan_t copy_a;
        rav_chan_t copy_b;
        rav_chan_t copy_c;
        logic [rav_pkg::CH_N-1:0][2:0] ok;
        logic [rav_pkg::NV_N-1:0][rav_pkg::DW-1:0] nonvoted;
        rav_chan_t voted;
        logic [rav_pkg::STAT_COUNT_W-1:0] scan_count;
        logic done;
        logic [31:0] rdata;
    } rav_state_all_t;

    rav_state_all_t cur;
    rav_state_all_t next_cur;

    logic [1:0] cfg_size;
    logic [1:0] cfg_policy;
    logic cfg_mode;
    logic [1:0] cfg_kind;
    logic [rav_pkg::DW-1:0] unit_result;
    logic [3:0] region;
    logic [rav_pkg::CW-1:0] sel;

    assign cfg_size = cur.ctrl[rav_pkg::CTRL_SIZE_LSB +: 2];
    assign cfg_policy = cur.ctrl[rav_pkg::CTRL_POLICY_LSB +: 2];
    assign cfg_mode = cur.ctrl[rav_pkg::CTRL_MODE_BIT];
    assign cfg_kind = cur.ctrl[rav_pkg::CTRL_KIND_LSB +: 2];
    assign region = addr_in[7:4];
    assign sel = addr_in[3:2];

    // ==========================================================
    // voting datapath, one channel per cycle
    rav_vote_unit u_vote
    (
        .copy_a_in(cur.copy_a[cur.idx]),
        .copy_b_in(cur.copy_b[cur.idx]),
        .copy_c_in(cur.copy_c[cur.idx]),
        .ok_in(cur.ok[cur.idx]),
        .size_in(cfg_size),
        .policy_in(cfg_policy),
        .mode_in(cfg_mode),
        .kind_in(cfg_kind),
        .min_in(cur.min_val[cur.idx]),
        .max_in(cur.max_val[cur.idx]),
        .last_in(cur.voted[cur.idx]),
        .voted_out(unit_result)
    );

    // ==========================================================
    // next state
    always_comb
    begin
        next_cur = cur;
        next_cur.done = 1'b0;
        next_cur.rdata = '0;

        case (cur.st)
            rav_pkg::RAV_ST_IDLE:
            begin
                if (scan_done_in)
                    next_cur.st = rav_pkg::RAV_ST_CAPTURE;
            end
            rav_pkg::RAV_ST_CAPTURE:
            begin
                for (int i = 0; i < rav_pkg::CH_N; i++)
                begin
                    next_cur.copy_a[i] =
                        copy_a_in[i*rav_pkg::DW +: rav_pkg::DW];
                    next_cur.copy_b[i] =
                        copy_b_in[i*rav_pkg::DW +: rav_pkg::DW];
                    next_cur.copy_c[i] =
                        copy_c_in[i*rav_pkg::DW +: rav_pkg::DW];
                    next_cur.ok[i] = ~(disc_fault_in[i*3 +: 3] | bus_fault_in);
                end
                for (int j = 0; j < rav_pkg::NV_N; j++)
                begin
                    next_cur.nonvoted[j] =
                        nonvoted_in[j*rav_pkg::DW +: rav_pkg::DW];
                end
                next_cur.idx = '0;
                next_cur.st = rav_pkg::RAV_ST_VOTE;
            end
            rav_pkg::RAV_ST_VOTE:
            begin
                next_cur.voted[cur.idx] = unit_result;
                if (cur.idx == rav_pkg::CW'(rav_pkg::CH_N - 1))
                    next_cur.st = rav_pkg::RAV_ST_DONE;
                else
                    next_cur.idx = cur.idx + 1'b1;
            end
            rav_pkg::RAV_ST_DONE:
            begin
                // application may start after this pulse
                next_cur.done = 1'b1;
                next_cur.scan_count = cur.scan_count + 1'b1;
                next_cur.st = rav_pkg::RAV_ST_IDLE;
            end
            default:
            begin
                next_cur.st = rav_pkg::RAV_ST_IDLE;
            end
        endcase

        // register writes; configuration may change between scans
        if (wr_in)
        begin
            if (addr_in == rav_pkg::OFS_CTRL)
                next_cur.ctrl = wdata_in[rav_pkg::CTRL_W-1:0];
            else if (region == rav_pkg::REG_MIN)
                next_cur.min_val[sel] = wdata_in[rav_pkg::DW-1:0];
            else if (region == rav_pkg::REG_MAX)
                next_cur.max_val[sel] = wdata_in[rav_pkg::DW-1:0];
        end

        // register reads, answered the next cycle
        if (rd_in && addr_in[1:0] == 2'b00)
        begin
            if (addr_in == rav_pkg::OFS_CTRL)
            begin
                next_cur.rdata = 32'(cur.ctrl);
            end
            else if (addr_in == rav_pkg::OFS_STATUS)
            begin
                next_cur.rdata[rav_pkg::STAT_BUSY_BIT] =
                    (cur.st != rav_pkg::RAV_ST_IDLE);
                next_cur.rdata[rav_pkg::STAT_COUNT_LSB +:
                    rav_pkg::STAT_COUNT_W] = cur.scan_count;
            end
            else
            begin
                case (region)
                    rav_pkg::REG_MIN: next_cur.rdata = 32'(cur.min_val[sel]);
                    rav_pkg::REG_MAX: next_cur.rdata = 32'(cur.max_val[sel]);
                    rav_pkg::TBL_VOTED:
                        next_cur.rdata = 32'(cur.voted[sel]);
                    rav_pkg::TBL_COPY_A: next_cur.rdata = 32'(cur.copy_a[sel]);
                    rav_pkg::TBL_COPY_B: next_cur.rdata = 32'(cur.copy_b[sel]);
                    rav_pkg::TBL_COPY_C: next_cur.rdata = 32'(cur.copy_c[sel]);
                    rav_pkg::TBL_NONVOTED:
                    begin
                        if (32'(sel) < rav_pkg::NV_N)
                            next_cur.rdata = 32'(cur.nonvoted[sel[0]]);
                    end
                    default: next_cur.rdata = '0;
                endcase
            end
        end
    end

    // ==========================================================
    // state register
    always_ff @(posedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            cur.st <= rav_pkg::RAV_ST_IDLE;
            cur.idx <= '0;
            cur.ctrl <= rav_pkg::CTRL_RESET;
            cur.min_val <= {rav_pkg::CH_N{rav_pkg::MIN_RESET}};
            cur.max_val <= {rav_pkg::CH_N{rav_pkg::MAX_RESET}};
            cur.copy_a <= {rav_pkg::CH_N{rav_pkg::VALUE_RESET}};
            cur.copy_b <= {rav_pkg::CH_N{rav_pkg::VALUE_RESET}};
            cur.copy_c <= {rav_pkg::CH_N{rav_pkg::VALUE_RESET}};
            cur.ok <= '0;
            cur.nonvoted <= {rav_pkg::NV_N{rav_pkg::VALUE_RESET}};
            cur.voted <= {rav_pkg::CH_N{rav_pkg::VALUE_RESET}};
            cur.scan_count <= '0;
            cur.done <= 1'b0;
            cur.rdata <= '0;
        end
        else
        begin
            cur <= next_cur;
        end
    end

    // ==========================================================
    // outputs
    assign rdata_out = cur.rdata;
    assign busy_out = (cur.st != rav_pkg::RAV_ST_IDLE);
    assign vote_done_out = cur.done;
    assign voted_out = cur.voted;
endmodule

/* design/rav_pkg.sv */
// constants, register map and encodings of the redundant analog input voter
package rav_pkg;
    localparam int CH_N = 4;
    localparam int NV_N = 2;
    localparam int DW = 16;
    localparam int AW = 8;
    localparam int CW = 2;

    // register byte addresses and address regions (address bits 7:4)
    localparam logic [AW-1:0] OFS_CTRL = 8'h00;
    localparam logic [AW-1:0] OFS_STATUS = 8'h04;
    localparam logic [3:0] REG_MIN = 4'h1;
    localparam logic [3:0] REG_MAX = 4'h2;
    localparam logic [3:0] TBL_VOTED = 4'h4;
    localparam logic [3:0] TBL_COPY_A = 4'h5;
    localparam logic [3:0] TBL_COPY_B = 4'h6;
    localparam logic [3:0] TBL_COPY_C = 4'h7;
    localparam logic [3:0] TBL_NONVOTED = 4'h8;

    // control field positions
    localparam int CTRL_SIZE_LSB = 0;
    localparam int CTRL_POLICY_LSB = 2;
    localparam int CTRL_MODE_BIT = 4;
    localparam int CTRL_KIND_LSB = 5;
    localparam int CTRL_W = 7;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 7'h03;

    // status field positions
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_COUNT_LSB = 8;
    localparam int STAT_COUNT_W = 8;

    localparam logic [DW-1:0] MIN_RESET = 16'h8000;
    localparam logic [DW-1:0] MAX_RESET = 16'h7FFF;
    localparam logic [DW-1:0] VALUE_RESET = 16'h0000;

    typedef enum logic [1:0]
    {
        RAV_SIZE_ONE = 2'h1,
        RAV_SIZE_TWO = 2'h2,
        RAV_SIZE_THREE = 2'h3
    } rav_size_t;

    typedef enum logic [1:0]
    {
        RAV_POL_HIGH = 2'h0,
        RAV_POL_LOW = 2'h1,
        RAV_POL_AVG = 2'h2
    } rav_policy_t;

    typedef enum logic
    {
        RAV_MODE_FULL = 1'b0,
        RAV_MODE_TRUNC = 1'b1
    } rav_mode_t;

    typedef enum logic [1:0]
    {
        RAV_DFLT_LAST = 2'h0,
        RAV_DFLT_MAX = 2'h1,
        RAV_DFLT_MIN = 2'h2
    } rav_kind_t;

    typedef enum logic [1:0]
    {
        RAV_ST_IDLE = 2'b00,
        RAV_ST_CAPTURE = 2'b01,
        RAV_ST_VOTE = 2'b11,
        RAV_ST_DONE = 2'b10
    } rav_state_t;
endpackage

/* design/rav_vote_unit.sv */
// combinational vote of one channel from up to three copies
module rav_vote_unit
(
    input wire logic signed [rav_pkg::DW-1:0] copy_a_in,
    input wire logic signed [rav_pkg::DW-1:0] copy_b_in,
    input wire logic signed [rav_pkg::DW-1:0] copy_c_in,
    input wire logic [2:0] ok_in,
    input wire logic [1:0] size_in,
    input wire logic [1:0] policy_in,
    input wire logic mode_in,
    input wire logic [1:0] kind_in,
    input wire logic signed [rav_pkg::DW-1:0] min_in,
    input wire logic signed [rav_pkg::DW-1:0] max_in,
    input wire logic signed [rav_pkg::DW-1:0] last_in,
    output logic signed [rav_pkg::DW-1:0] voted_out
);
    logic [2:0] live;
    logic [1:0] n_live;
    logic signed [rav_pkg::DW-1:0] first;
    logic signed [rav_pkg::DW-1:0] second;
    logic signed [rav_pkg::DW-1:0] dflt;
    logic signed [rav_pkg::DW:0] sum;
    logic signed [rav_pkg::DW:0] half;

    function automatic logic signed [rav_pkg::DW-1:0] median3
    (
        input logic signed [rav_pkg::DW-1:0] x,
        input logic signed [rav_pkg::DW-1:0] y,
        input logic signed [rav_pkg::DW-1:0] z
    );
        logic signed [rav_pkg::DW-1:0] lo;
        logic signed [rav_pkg::DW-1:0] hi;
        lo = (x < y) ? x : y;
        hi = (x < y) ? y : x;
        // equal candidates fall out as the repeated value
        median3 = (z < lo) ? lo : ((z > hi) ? hi : z);
    endfunction

    always_comb
    begin
        // copies outside the configured group never take part
        case (size_in)
            rav_pkg::RAV_SIZE_ONE: live = ok_in & 3'b001;
            rav_pkg::RAV_SIZE_TWO: live = ok_in & 3'b011;
            default: live = ok_in;
        endcase
        n_live = 2'(live[0]) + 2'(live[1]) + 2'(live[2]);
        first = live[0] ? copy_a_in : (live[1] ? copy_b_in : copy_c_in);
        second = (live[0] && live[1]) ? copy_b_in : copy_c_in;
        case (kind_in)
            rav_pkg::RAV_DFLT_MAX: dflt = max_in;
            rav_pkg::RAV_DFLT_MIN: dflt = min_in;
            default: dflt = last_in;
        endcase
        sum = 17'(first) + 17'(second);
        // truncate toward zero for negative sums
        half = (sum + 17'(sum[rav_pkg::DW])) >>> 1;
        if (size_in == rav_pkg::RAV_SIZE_ONE)
        begin
            voted_out = live[0] ? copy_a_in : dflt;
        end
        else
        begin
            case (n_live)
                2'd3:
                    voted_out = median3(copy_a_in, copy_b_in, copy_c_in);
                2'd2:
                begin
                    case (policy_in)
                        rav_pkg::RAV_POL_LOW:
                            voted_out = median3(first, second, min_in);
                        rav_pkg::RAV_POL_AVG:
                            voted_out = half[rav_pkg::DW-1:0];
                        default:
                            voted_out = median3(first, second, max_in);
                    endcase
                end
                2'd1:
                begin
                    if (mode_in == rav_pkg::RAV_MODE_FULL)
                        voted_out = first;
                    else
                        voted_out = dflt;
                end
                default: voted_out = dflt;
            endcase
        end
    end
endmodule

/* sim/rav_voter_assertions.sv */
// concurrent checks on the ports of the analog input voter
module rav_voter_assertions
(
    input wire logic clk_sys_in,
    input wire logic nrst_in,
    input wire logic scan_done_in,
    input wire logic [rav_pkg::AW-1:0] addr_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [31:0] rdata_out,
    input wire logic busy_out,
    input wire logic vote_done_out,
    input wire logic [rav_pkg::CH_N*rav_pkg::DW-1:0] voted_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!nrst_in);
    // ==========================================
    // scan sequencing
    AST_DONE_LAT: assert property (
        scan_done_in && !busy_out |-> ##7 vote_done_out)
        else $error("vote done not seven cycles after scan");
    AST_BUSY_SPAN: assert property (
        scan_done_in && !busy_out |=> busy_out [*6] ##1 !busy_out)
        else $error("busy span wrong");
    AST_DONE_PULSE: assert property (
        vote_done_out |=> !vote_done_out)
        else $error("vote done longer than one cycle");
    AST_DONE_IDLE: assert property (
        vote_done_out |-> !busy_out && $past(busy_out))
        else $error("vote done outside end of vote");
    AST_VOTED_HOLD: assert property (
        !busy_out |-> $stable(voted_out))
        else $error("voted values moved while idle");
    // ==========================================
    // table readout
    AST_RDATA_IDLE: assert property (
        !$past(rd_in) |-> rdata_out == 32'h0000_0000)
        else $error("read data without read");
    AST_MISALIGN: assert property (
        rd_in && addr_in[1:0] != 2'h0 |=> rdata_out == 32'h0000_0000)
        else $error("misaligned read not zero");
    AST_STATUS_BUSY: assert property (
        rd_in && addr_in == rav_pkg::OFS_STATUS
        |=> rdata_out[0] == $past(busy_out))
        else $error("status busy bit wrong");
    COV_SCAN: cover property (scan_done_in && !busy_out);
    COV_DONE: cover property (vote_done_out);
    COV_RD_VOTED: cover property (rd_in && addr_in[7:4] == 4'h4);
    COV_WR: cover property (wr_in);
endmodule

bind rav_voter rav_voter_assertions u_chk
(
    .clk_sys_in(clk_sys_in),
    .nrst_in(nrst_in),
    .scan_done_in(scan_done_in),
    .addr_in(addr_in),
    .wr_in(wr_in),
    .rd_in(rd_in),
    .rdata_out(rdata_out),
    .busy_out(busy_out),
    .vote_done_out(vote_done_out),
    .voted_out(voted_out)
);

/* sim/rav_input_model.sv */
// model of the redundant input blocks feeding the voter
module rav_input_model
(
    input wire logic clk_sys_in,
    input wire logic nrst_in,
    input wire logic start_in,
    input wire logic vote_done_in,
    input wire logic [rav_pkg::CH_N*rav_pkg::DW-1:0] a_in,
    input wire logic [rav_pkg::CH_N*rav_pkg::DW-1:0] b_in,
    input wire logic [rav_pkg::CH_N*rav_pkg::DW-1:0] c_in,
    output logic scan_done_out,
    output logic [rav_pkg::CH_N*rav_pkg::DW-1:0] copy_a_out,
    output logic [rav_pkg::CH_N*rav_pkg::DW-1:0] copy_b_out,
    output logic [rav_pkg::CH_N*rav_pkg::DW-1:0] copy_c_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================
    // scan fills copies; once voted they no longer hold
    always_ff @(posedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            scan_done_out <= 1'b0;
            copy_a_out <= '0;
            copy_b_out <= '0;
            copy_c_out <= '0;
        end
        else
        begin
            scan_done_out <= start_in;
            if (start_in)
            begin
                copy_a_out <= a_in;
                copy_b_out <= b_in;
                copy_c_out <= c_in;
            end
            else if (vote_done_in)
            begin
                copy_a_out <= ~copy_a_out;
                copy_b_out <= ~copy_b_out;
                copy_c_out <= ~copy_c_out;
            end
        end
    end
endmodule

/* sim/tb_top.sv */
// testbench for the redundant analog input voter
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int W = rav_pkg::CH_N * rav_pkg::DW;
    logic clk_sys_in = 1'b0;
    logic nrst_in, scan_done, start, wr_in, rd_in, busy_out, vote_done_out;
    logic [7:0] addr_in;
    logic [31:0] wdata_in, rdata_out, nonvoted_in;
    logic [W-1:0] va, vb, vc, cpa, cpb, cpc, voted_out;
    logic [11:0] disc;
    logic [2:0] bus_fault_in;
    logic [15:0] exp_v [4];
    int num_errors = 0;
    int check_count = 0;
    always #10ns clk_sys_in = ~clk_sys_in;
    rav_input_model u_model
    (
        .clk_sys_in(clk_sys_in),
        .nrst_in(nrst_in),
        .start_in(start),
        .vote_done_in(vote_done_out),
        .a_in(va),
        .b_in(vb),
        .c_in(vc),
        .scan_done_out(scan_done),
        .copy_a_out(cpa),
        .copy_b_out(cpb),
        .copy_c_out(cpc)
    );
    rav_voter uut
    (
        .clk_sys_in(clk_sys_in),
        .nrst_in(nrst_in),
        .scan_done_in(scan_done),
        .copy_a_in(cpa),
        .copy_b_in(cpb),
        .copy_c_in(cpc),
        .disc_fault_in(disc),
        .bus_fault_in(bus_fault_in),
        .nonvoted_in(nonvoted_in),
        .addr_in(addr_in),
        .wdata_in(wdata_in),
        .wr_in(wr_in),
        .rd_in(rd_in),
        .rdata_out(rdata_out),
        .busy_out(busy_out),
        .vote_done_out(vote_done_out),
        .voted_out(voted_out)
    );
    // ==========================================
    // checking, bus cycles and expected votes
    task automatic chk(input string nm, input logic [31:0] s, e);
        check_count++;
        if (s !== e)
        begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_sys_in);
        wr_in <= 1'b0;
    endtask
    task automatic rd(input string nm, input logic [7:0] a,
        input logic [31:0] e);
        @(posedge clk_sys_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_sys_in);
        rd_in <= 1'b0;
        #1;
        chk(nm, rdata_out, e);
    endtask
    function automatic logic [15:0] med(input logic signed [15:0] x, y, z);
        if ((x >= y && x <= z) || (x <= y && x >= z))
            return x;
        if ((y >= x && y <= z) || (y <= x && y >= z))
            return y;
        return z;
    endfunction
    function automatic logic [15:0] ref_v(input logic signed [15:0] a, b, c,
        mn, mx, ls, input logic [2:0] f, input logic [6:0] cf);
        logic [2:0] ok;
        logic signed [16:0] s;
        int n;
        ok = ~f & (cf[1:0] == 2'h1 ? 3'h1 : cf[1:0] == 2'h2 ? 3'h3 : 3'h7);
        n = ok[0] + ok[1] + ok[2];
        s = (ok[0] ? a : b) + (ok[2] ? c : b);
        if (n == 3)
            return med(a, b, c);
        if (n == 2 && cf[3:2] == 2'h2)
            return 16'(s / 2);
        if (n == 2)
            return med(ok[0] ? a : b, ok[2] ? c : b, cf[3:2] == 2'h1 ? mn : mx);
        if (n == 1 && (!cf[4] || cf[1:0] == 2'h1))
            return ok[0] ? a : ok[1] ? b : c;
        return cf[6:5] == 2'h1 ? mx : cf[6:5] == 2'h2 ? mn : ls;
    endfunction
    task automatic scan(input int i);
        logic [6:0] cf;
        int n, k;
        cf = 7'((i / 18 % 3) * 32 + (i / 9 % 2) * 16);
        cf = cf + 7'((i / 3 % 3) * 4 + i % 3 + 1);
        // one extra scan uses the reserved size and policy codes
        if (i == 54)
            cf[3:0] = 4'hC;
        wr(rav_pkg::OFS_CTRL, 32'(cf));
        for (n = 0; n < 4; n++)
        begin
            va[n*16 +: 16] <= 16'(i * 97 + n * 13 - 900);
            vb[n*16 +: 16] <= 16'(700 - i * 53 + n * 5);
            vc[n*16 +: 16] <= 16'(i * 11 - n * 29 + 3);
            disc[n*3 +: 3] <= 3'((i + n * 3) % 8);
        end
        bus_fault_in <= (i % 7 == 6) ? 3'h4 : 3'h0;
        start <= 1'b1;
        @(posedge clk_sys_in);
        start <= 1'b0;
        if (i == 5)
        begin
            repeat (2) @(posedge clk_sys_in);
            start <= 1'b1;
            @(posedge clk_sys_in);
            start <= 1'b0;
        end
        for (k = 0; k < 20 && vote_done_out !== 1'b1; k++)
            @(posedge clk_sys_in) #1;
        chk("vote_done", 32'(vote_done_out), 32'h0000_0001);
        for (n = 0; n < 4; n++)
        begin
            exp_v[n] = ref_v(va[n*16 +: 16], vb[n*16 +: 16], vc[n*16 +: 16],
                16'(n - 200), 16'(n + 400), exp_v[n],
                disc[n*3 +: 3] | bus_fault_in, cf);
            chk("voted",
                32'(voted_out[n*16 +: 16]),
                32'(exp_v[n]));
        end
        n = i % 4;
        rd("voted_reg", 8'(8'h40 + n * 4), 32'(exp_v[n]));
        rd("copy_a", 8'(8'h50 + n * 4), 32'(va[n*16 +: 16]));
    endtask
    task automatic complete_run();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // ==========================================
    // main sequence and watchdog
    initial
    begin
        #100us;
        num_errors++;
        complete_run();
    end
    initial
    begin
        nrst_in <= 1'b0;
        {start, wr_in, rd_in, addr_in, wdata_in} <= '0;
        {va, vb, vc, disc, bus_fault_in} <= '0;
        nonvoted_in <= 32'h1234_5678;
        exp_v = '{default: 16'h0000};
        repeat (10) @(posedge clk_sys_in);
        nrst_in <= 1'b1;
        rd("ctrl", rav_pkg::OFS_CTRL, 32'h0000_0003);
        rd("min0", 8'h10, 32'h0000_8000);
        rd("max3", 8'h2C, 32'h0000_7FFF);
        rd("status", rav_pkg::OFS_STATUS, 32'h0000_0000);
        for (int n = 0; n < 4; n++)
        begin
            wr(8'(8'h10 + n * 4), 32'(16'(n - 200)));
            wr(8'(8'h20 + n * 4), 32'(16'(n + 400)));
        end
        for (int i = 0; i < 55; i++)
            scan(i);
        rd("nonvoted0", 8'h80, 32'h0000_5678);
        rd("nonvoted1", 8'h84, 32'h0000_1234);
        rd("misaligned", 8'h41, 32'h0000_0000);
        rd("unmapped", 8'h90, 32'h0000_0000);
        wr(rav_pkg::OFS_STATUS, 32'h0000_FFFF);
        rd("scan_count", rav_pkg::OFS_STATUS, 32'h0000_3700);
        complete_run();
    end
endmodule
